// ==== logic/pa_alarm_consts.vh ====
`ifndef PA_ALARM_CONSTS_VH
`define PA_ALARM_CONSTS_VH
// register indices, byte address is four times the index
`define IDX_LOOP_CFG 8'h10
`define IDX_MON_CFG 8'h11
`define IDX_ALM_CFG 8'h1B
`define IDX_ALM_MASK 8'h1C
`define IDX_ALM_CLAMP 8'h1D
`define IDX_ALM_STAT 8'h1E
`define IDX_GEN_STAT 8'h1F
`define IDX_CS_RES 8'h29
`define IDX_CS_RES_LAST 8'h2C
`define IDX_THR 8'h40
`define IDX_THR_LAST 8'h47
// loop_and_filter_config fields
`define FLD_FILTER_LSB 0
`define FLD_LOOP_EN 3
// monitor_config_one fields
`define FLD_NEG_LINK 0
`define FLD_DS_REQ 1
`define FLD_SLEEP_EN 2
// alarm_output_config fields
`define FLD_POLARITY 0
`define FLD_LATCH_DIS 1
`define FLD_SRC_SEL 2
// alarm clamp register: dac bits 3:0, drain switch off bit
`define FLD_CLAMP_DS 4
// alarm_source_status fields: monitors in 3:0
`define FLD_ST_NEG 4
`define FLD_ST_POS 5
// general_status fields
`define FLD_GLOBAL_ALARM_FLAG 0
`define FLD_DS_STATE 1
`define FLD_ALM_ACT 2
// reset values
`define RST_LOOP_CFG 8'h00
`define RST_MON_CFG 8'h01
`define RST_ALM_CFG 8'h00
`define RST_ALM_MASK 8'h00
`define RST_ALM_CLAMP 8'h00
`define RST_THR_LO 12'h000
`define RST_THR_HI 12'hFFF
// largest valid filter code and fraction bits of the filter
`define FILTER_MAX 3'h4
`define FILT_FRAC 4
`endif

// ==== logic/cs_filter.v ====
`timescale 1ns/10ps
`default_nettype none
`include "pa_alarm_consts.vh"
// first-order recursive smoothing of one current-sense channel
module cs_filter (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire [2:0] k_code_in,
    input wire [11:0] code_in,
    input wire valid_in,
    output wire [11:0] result_out,
    output reg valid_out
);
    // accumulator carries fraction bits to avoid drift
    reg [15:0] acc;
    // new sample scaled to the accumulator grid
    wire [16:0] x_ext = {1'b0, code_in, 4'h0};
    // signed step between sample and running value
    wire [16:0] diff = x_ext - {1'b0, acc};
    // shift amount, invalid codes fall back to k equal one
    wire [2:0] sh = (k_code_in > `FILTER_MAX) ? 3'h0 : k_code_in;
    wire [16:0] step = $signed(diff) >>> sh;
    // y += (x - y) / k on every conversion
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            acc <= 16'h0000;
            valid_out <= 1'b0;
        end else begin
            valid_out <= valid_in;
            if (valid_in) begin
                acc <= acc + step[15:0]; // [R4] [R5]
            end
        end
    end
    // unsigned straight-binary result
    assign result_out = acc[15:`FILT_FRAC]; // [R1]
endmodule
`default_nettype wire

// ==== logic/range_check.v ====
`timescale 1ns/10ps
`default_nettype none
// compares one sample with its lower and upper limits
module range_check (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire [11:0] value_in,
    input wire [11:0] lower_in,
    input wire [11:0] upper_in,
    input wire valid_in,
    output reg out_of_range_out,
    output reg done_out
);
    // verdict held until the next checked sample
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            out_of_range_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= valid_in;
            if (valid_in) begin
                out_of_range_out <= (value_in < lower_in) ||
                    (value_in > upper_in); // [R12]
            end
        end
    end
endmodule
`default_nettype wire

// ==== logic/pa_alarm_and_drain_switch_logic.v ====
// Added by the designer: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "pa_alarm_consts.vh"
// What this block does
// [R1] results stored unsigned, 0.2/4096 volt per code
// [R2] loop-enable bit selects standalone or closed loop
// [R3] closed loop lets controllers drive bipolar DACs
// [R4] first-order recursive filter on sense results
// [R5] filter code sets k from one to sixteen
// [R6] drain switch off after reset
// [R7] drain switch written or forced by events
// [R8] positive supply fault forces drain switch off
// [R9] linked negative supply fault blocks switch on
// [R10] negative supply link set by default
// [R11] out of range sets global flag and source
// [R12] lower and upper limits judge each input
// [R13] latched status clears on read, re-arms
// [R14] unlatched status follows its condition
// [R15] alarm pin polarity from config bit
// [R16] unmasked events drive pin, masked only status
// [R17] active alarm clamps chosen DACs, drain off
// [R18] clearing alarms releases neither clamp nor switch
// [R19] select low in closed loop checks DAC monitors
// [R20] host reads status after seeing alarm pin
// [R21] select high in open loop checks sense inputs
// [R22] unforced writes set switch on or off
module pa_alarm_and_drain_switch_logic (
    input wire ref_clk_in,
    input wire rst_n_in,
    input wire psel_in,
    input wire penable_in,
    input wire pwrite_in,
    input wire [11:0] paddr_in,
    input wire [31:0] pwdata_in,
    output reg [31:0] prdata_out,
    output reg pready_out,
    output reg pslverr_out,
    input wire [47:0] cs_code_in,
    input wire [3:0] cs_valid_in,
    input wire [47:0] dac_mon_code_in,
    input wire [3:0] dac_mon_valid_in,
    input wire neg_supply_fault_in,
    input wire pos_supply_fault_in,
    input wire sleep_in,
    output reg drain_switch_control_out,
    output reg alarm_pin_drive_out,
    output reg alarm_pin_oe_out,
    output reg [3:0] dac_clamp_out,
    output reg closed_loop_enable_out
);
    // software registers
    reg [7:0] loop_and_filter_config;
    reg [7:0] monitor_config_one;
    reg [7:0] alarm_output_config;
    reg [7:0] alarm_mask;
    reg [7:0] alarm_clamp;
    reg [5:0] alarm_source_status;
    // limit pairs per monitored channel
    wire [11:0] thr_lo [0:3];
    wire [11:0] thr_hi [0:3];
    // drain switch state, one means conducting
    reg ds_on;
    // dac clamps held until released by software
    reg [3:0] clamp_hold;
    // alarm output level before polarity
    reg alarm_act;

    // decoded bus access
    wire [7:0] idx = paddr_in[9:2];
    // address inside the map and word aligned
    wire addr_ok = (paddr_in[1:0] == 2'h0) &&
        (paddr_in[11:10] == 2'h0);
    // completing edge of a transfer
    wire done = psel_in && penable_in && pready_out;
    wire wr = done && pwrite_in && addr_ok;
    wire rd_clr = done && !pwrite_in && addr_ok &&
        (idx == `IDX_ALM_STAT);

    // config fields
    wire [2:0] k_code = loop_and_filter_config[2:0];
    wire loop_en = loop_and_filter_config[`FLD_LOOP_EN];
    wire src_sel = alarm_output_config[`FLD_SRC_SEL];
    wire latch_dis = alarm_output_config[`FLD_LATCH_DIS];
    wire polarity = alarm_output_config[`FLD_POLARITY];
    // detection enabled only for matching mode and select
    // other pairings idle the checks
    wire det_en = src_sel ? !loop_en : loop_en; // [R19] [R21]

    // per channel filter and limit check
    wire [11:0] filt_w [0:3];
    wire [3:0] filt_vld;
    wire [3:0] oor;
    wire [3:0] chk_done;
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : chan
            // indices of this channel's limit registers
            localparam [31:0] LO_NUM = `IDX_THR + 2 * g;
            localparam [31:0] HI_NUM = `IDX_THR + 2 * g + 1;
            localparam [7:0] LO_IDX = LO_NUM[7:0];
            localparam [7:0] HI_IDX = HI_NUM[7:0];
            // value that the limits judge
            wire [11:0] mon_val;
            wire mon_vld;
            assign mon_val = src_sel ? filt_w[g] :
                dac_mon_code_in[12*g+11:12*g];
            assign mon_vld = det_en &&
                (src_sel ? filt_vld[g] : dac_mon_valid_in[g]);
            cs_filter u_filt (
                .ref_clk_in(ref_clk_in),
                .rst_n_in(rst_n_in),
                .k_code_in(k_code),
                .code_in(cs_code_in[12*g+11:12*g]),
                .valid_in(cs_valid_in[g]),
                .result_out(filt_w[g]),
                .valid_out(filt_vld[g])
            );
            range_check u_chk (
                .ref_clk_in(ref_clk_in),
                .rst_n_in(rst_n_in),
                .value_in(mon_val),
                .lower_in(thr_lo[g]),
                .upper_in(thr_hi[g]),
                .valid_in(mon_vld),
                .out_of_range_out(oor[g]),
                .done_out(chk_done[g])
            );
            // limit registers of this channel
            reg [11:0] lo_lim;
            reg [11:0] hi_lim;
            always @(posedge ref_clk_in) begin
                if (!rst_n_in) begin
                    lo_lim <= `RST_THR_LO;
                    hi_lim <= `RST_THR_HI;
                end else if (wr && idx == LO_IDX) begin
                    lo_lim <= pwdata_in[11:0]; // [R12]
                end else if (wr && idx == HI_IDX) begin
                    hi_lim <= pwdata_in[11:0]; // [R12]
                end
            end
            assign thr_lo[g] = lo_lim;
            assign thr_hi[g] = hi_lim;
        end
    endgenerate

    // current condition of every source
    // supplies checked every cycle
    wire [5:0] cond = {pos_supply_fault_in, neg_supply_fault_in,
        oor & {4{det_en}}};
    // sources that report on this cycle
    wire [5:0] upd = {2'h3, chk_done};

    // status next value
    reg [5:0] next_status;
    always @* begin
        if (latch_dis) begin
            // unlatched: follows the condition
            next_status = (alarm_source_status & ~upd) |
                (cond & upd); // [R14]
        end else begin
            // latched: read clears, a new event wins
            // no event lost on the clearing edge
            next_status = (alarm_source_status &
                {6{!rd_clr}}) | (cond & upd); // [R13] [R11]
        end
    end

    // alarm output active for unmasked status
    wire next_act = |(next_status & ~alarm_mask[5:0]); // [R16]

    // forcing conditions for the drain switch
    // pos fault needs no enable
    wire force_off = pos_supply_fault_in || // [R8]
        (neg_supply_fault_in &&
        monitor_config_one[`FLD_NEG_LINK]) || // [R9] [R10]
        (alarm_act && alarm_clamp[`FLD_CLAMP_DS]) || // [R17]
        (sleep_in && monitor_config_one[`FLD_SLEEP_EN]); // [R7]

    // read data mux
    // upper bits read as zero
    reg [31:0] next_rdata;
    reg next_err;
    reg [7:0] sel;
    always @* begin
        next_rdata = 32'h00000000;
        next_err = 1'b0;
        sel = idx - `IDX_THR;
        if (!addr_ok) begin
            // outside the map
            next_err = 1'b1;
        end else if (idx >= `IDX_THR && idx <= `IDX_THR_LAST) begin
            // limit pair, even index lower, odd upper
            next_rdata[11:0] = sel[0] ? thr_hi[sel[2:1]] :
                thr_lo[sel[2:1]];
        end else if (idx >= `IDX_CS_RES &&
            idx <= `IDX_CS_RES_LAST) begin
            // filtered sense result per channel
            sel = idx - `IDX_CS_RES;
            next_rdata[11:0] = filt_w[sel[1:0]]; // [R1]
        end else begin
            case (idx)
                `IDX_LOOP_CFG: begin
                    next_rdata[7:0] = loop_and_filter_config;
                end
                `IDX_MON_CFG: begin
                    next_rdata[7:0] = monitor_config_one;
                end
                `IDX_ALM_CFG: begin
                    next_rdata[7:0] = alarm_output_config;
                end
                `IDX_ALM_MASK: begin
                    next_rdata[7:0] = alarm_mask;
                end
                `IDX_ALM_CLAMP: begin
                    next_rdata[7:0] = alarm_clamp;
                end
                `IDX_ALM_STAT: begin
                    next_rdata[5:0] = alarm_source_status;
                end
                `IDX_GEN_STAT: begin
                    next_rdata[`FLD_GLOBAL_ALARM_FLAG] = |alarm_source_status;
                    next_rdata[`FLD_DS_STATE] = ds_on;
                    next_rdata[`FLD_ALM_ACT] = alarm_act;
                end
                default: begin
                    // unmapped word
                    next_err = 1'b1;
                end
            endcase
        end
    end

    // apb slave, one wait state before pready
    // pready lasts one cycle
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h00000000;
        end else if (psel_in && penable_in && !pready_out) begin
            // answer during the access phase
            pready_out <= 1'b1;
            pslverr_out <= next_err;
            prdata_out <= pwrite_in ? 32'h00000000 : next_rdata;
        end else begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
        end
    end

    // configuration registers
    // status words not writable
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            loop_and_filter_config <= `RST_LOOP_CFG;
            monitor_config_one <= `RST_MON_CFG; // [R10]
            alarm_output_config <= `RST_ALM_CFG; // [R15]
            alarm_mask <= `RST_ALM_MASK;
            alarm_clamp <= `RST_ALM_CLAMP;
        end else if (wr) begin
            case (idx)
                `IDX_LOOP_CFG: begin
                    loop_and_filter_config <= pwdata_in[7:0]; // [R2]
                end
                `IDX_MON_CFG: begin
                    monitor_config_one <= pwdata_in[7:0];
                end
                `IDX_ALM_CFG: begin
                    alarm_output_config <= pwdata_in[7:0];
                end
                `IDX_ALM_MASK: begin
                    alarm_mask <= pwdata_in[7:0];
                end
                `IDX_ALM_CLAMP: begin
                    alarm_clamp <= pwdata_in[7:0];
                end
                default: begin
                    // limits written per channel, read-only or unmapped ignored
                end
            endcase
        end
    end

    // alarm status and output level
    // pin lags status by a cycle
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            alarm_source_status <= 6'h00;
            alarm_act <= 1'b0;
        end else begin
            alarm_source_status <= next_status; // [R11]
            alarm_act <= next_act; // [R16]
        end
    end

    // clamp hold, released only by a clamp write while idle
    // alarm holds clamps on
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            clamp_hold <= 4'h0;
        end else if (pos_supply_fault_in) begin
            // positive supply fault clamps every dac
            clamp_hold <= 4'hF;
        end else if (alarm_act) begin
            clamp_hold <= clamp_hold | alarm_clamp[3:0]; // [R17]
        end else if (wr && idx == `IDX_ALM_CLAMP) begin
            clamp_hold <= 4'h0; // [R18]
        end
    end

    // drain switch state
    // faults beat writes
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            ds_on <= 1'b0; // [R6]
        end else if (force_off) begin
            // forced off, on-requests ignored
            ds_on <= 1'b0; // [R7] [R9]
        end else if (wr && idx == `IDX_MON_CFG) begin
            // stays off after alarm until rewritten
            ds_on <= pwdata_in[`FLD_DS_REQ]; // [R22] [R18]
        end
    end

    // registered outputs
    // force gates output at once
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            drain_switch_control_out <= 1'b0; // [R6]
            alarm_pin_drive_out <= 1'b0;
            alarm_pin_oe_out <= 1'b0;
            dac_clamp_out <= 4'h0;
            closed_loop_enable_out <= 1'b0;
        end else begin
            drain_switch_control_out <= ds_on && !force_off;
            // open drain: pull low for active-low alarm
            alarm_pin_drive_out <= 1'b0;
            alarm_pin_oe_out <= polarity ? !alarm_act :
                alarm_act; // [R15]
            dac_clamp_out <= clamp_hold; // [R17]
            closed_loop_enable_out <= loop_en; // [R2] [R3]
        end
    end
endmodule
`default_nettype wire

// ==== test/pa_alarm_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
// checks switch, clamp and pin outputs against their causes
module pa_alarm_monitor (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic pready_out,
    input wire logic pslverr_out,
    input wire logic neg_supply_fault_in,
    input wire logic pos_supply_fault_in,
    input wire logic sleep_in,
    input wire logic drain_switch_control_out,
    input wire logic alarm_pin_drive_out,
    input wire logic alarm_pin_oe_out,
    input wire logic [3:0] dac_clamp_out,
    input wire logic closed_loop_enable_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    // a write completing at this edge
    wire logic wr = psel_in & penable_in & pready_out & pwrite_in;
    wire logic wr_on = wr & (paddr_in == 12'h044) & pwdata_in[1];
    wire logic wr_clamp = wr & (paddr_in == 12'h074);
    logic [2:0] cfg; // tracked link, request and sleep enable
    // follows writes to monitor_config_one
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            cfg <= 3'h1;
        end else if (wr && paddr_in == 12'h044) begin
            cfg <= pwdata_in[2:0];
        end
    end
    a_reset_all_off: assert property (
        !rst_n_in |=> !drain_switch_control_out && !alarm_pin_oe_out
        && dac_clamp_out == 4'h0) else $error("outputs active in reset");
    a_pos_fault_off: assert property (disable iff (!rst_n_in)
        pos_supply_fault_in |-> ##[1:2] !drain_switch_control_out)
        else $error("switch on under positive fault");
    a_neg_link_off: assert property (disable iff (!rst_n_in)
        neg_supply_fault_in && cfg[0] |-> ##[1:2] !drain_switch_control_out)
        else $error("switch on under linked negative fault");
    a_sleep_off: assert property (disable iff (!rst_n_in)
        sleep_in && cfg[2] |-> ##[1:2] !drain_switch_control_out)
        else $error("switch on during enabled sleep");
    a_switch_on_cause: assert property (disable iff (!rst_n_in)
        $rose(drain_switch_control_out) |-> $past(wr_on) || $past(wr_on, 2))
        else $error("switch turned on without a write");
    a_clamp_hold: assert property (disable iff (!rst_n_in)
        |($past(dac_clamp_out) & ~dac_clamp_out) |-> $past(wr_clamp)
        || $past(wr_clamp, 2) || $past(pos_supply_fault_in, 2))
        else $error("clamp released without a write");
    a_loop_copy: assert property (disable iff (!rst_n_in)
        wr && paddr_in == 12'h040 |-> ##2
        closed_loop_enable_out == $past(pwdata_in[3], 2))
        else $error("loop enable output does not follow");
    a_pin_open_drain: assert property (disable iff (!rst_n_in)
        !alarm_pin_drive_out) else $error("alarm pin driven high");
    // main scenarios reached
    c_switch_on: cover property ($rose(drain_switch_control_out));
    c_pin_on: cover property ($rose(alarm_pin_oe_out));
    c_bus_error: cover property (pready_out && pslverr_out);
endmodule
bind pa_alarm_and_drain_switch_logic pa_alarm_monitor u_mon (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .neg_supply_fault_in(neg_supply_fault_in),
    .pos_supply_fault_in(pos_supply_fault_in), .sleep_in(sleep_in),
    .drain_switch_control_out(drain_switch_control_out),
    .alarm_pin_drive_out(alarm_pin_drive_out),
    .alarm_pin_oe_out(alarm_pin_oe_out), .dac_clamp_out(dac_clamp_out),
    .closed_loop_enable_out(closed_loop_enable_out));
`default_nettype wire

// ==== test/apb_host_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// apb master standing in for the host processor
module apb_host_model (
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic cmd_valid_in,
    input wire logic cmd_write_in,
    input wire logic [11:0] cmd_addr_in,
    input wire logic [31:0] cmd_wdata_in,
    input wire logic pready_in,
    input wire logic [31:0] prdata_in,
    input wire logic pslverr_in,
    output logic psel_out,
    output logic penable_out,
    output logic pwrite_out,
    output logic [11:0] paddr_out,
    output logic [31:0] pwdata_out,
    output logic done_out,
    output logic [31:0] rdata_out,
    output logic err_out
);
    logic [1:0] state; // idle, setup, access, done
    // one transfer per command, held until pready is sampled
    always @(posedge ref_clk_in) begin
        if (!rst_n_in) begin
            state <= 2'h0;
            psel_out <= 1'h0;
            penable_out <= 1'h0;
            done_out <= 1'h0;
        end else begin
            case (state)
                2'h0: if (cmd_valid_in) begin
                    psel_out <= 1'h1;
                    pwrite_out <= cmd_write_in;
                    paddr_out <= cmd_addr_in;
                    pwdata_out <= cmd_wdata_in;
                    state <= 2'h1;
                end
                2'h1: begin
                    penable_out <= 1'h1;
                    state <= 2'h2;
                end
                2'h2: if (pready_in) begin
                    psel_out <= 1'h0;
                    penable_out <= 1'h0;
                    rdata_out <= prdata_in;
                    err_out <= pslverr_in;
                    done_out <= 1'h1;
                    state <= 2'h3;
                end
                // wait for the command to be withdrawn
                default: if (!cmd_valid_in) begin
                    done_out <= 1'h0;
                    state <= 2'h0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ==== test/pa_alarm_and_drain_switch_logic_tb_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// register level tests of the alarm and drain switch block
module pa_alarm_and_drain_switch_logic_tb_top;
    logic clk, rst_n = 1'h0, cv = 1'h0, cw = 1'h0;
    logic psel, pen, pwr, rdy, serr, done, err, ds, drv, oe, loop;
    logic neg = 1'h0, pos = 1'h0, sleep = 1'h0;
    logic [11:0] ca = 12'h000, pa, fexp;
    logic [31:0] cd = 32'h0, pwd, prd, rdata;
    logic [47:0] csc = 48'h0, dmc = 48'h0;
    logic [3:0] csv = 4'h0, dmv = 4'h0, clamp;
    int num_errors = 0, n_tests = 0;
    pa_alarm_and_drain_switch_logic uut (.ref_clk_in(clk),
        .rst_n_in(rst_n), .psel_in(psel), .penable_in(pen),
        .pwrite_in(pwr), .paddr_in(pa), .pwdata_in(pwd), .prdata_out(prd),
        .pready_out(rdy), .pslverr_out(serr), .cs_code_in(csc),
        .cs_valid_in(csv), .dac_mon_code_in(dmc), .dac_mon_valid_in(dmv),
        .neg_supply_fault_in(neg), .pos_supply_fault_in(pos),
        .sleep_in(sleep), .drain_switch_control_out(ds),
        .alarm_pin_drive_out(drv), .alarm_pin_oe_out(oe),
        .dac_clamp_out(clamp), .closed_loop_enable_out(loop));
    apb_host_model host (.ref_clk_in(clk), .rst_n_in(rst_n),
        .cmd_valid_in(cv), .cmd_write_in(cw), .cmd_addr_in(ca),
        .cmd_wdata_in(cd), .pready_in(rdy), .prdata_in(prd),
        .pslverr_in(serr), .psel_out(psel), .penable_out(pen),
        .pwrite_out(pwr), .paddr_out(pa), .pwdata_out(pwd),
        .done_out(done), .rdata_out(rdata), .err_out(err));
    // free running clock
    initial begin
        clk = 1'h0;
        forever #2 clk = ~clk;
    end
    // counts and reports one comparison
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e) begin
            num_errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask
    // one register access through the host model
    task automatic xfer(input logic w, input logic [7:0] idx,
        input logic [31:0] d);
        int i;
        @(posedge clk);
        cw <= w;
        ca <= {2'h0, idx, 2'h0};
        cd <= d;
        cv <= 1'h1;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (done !== 1'h1 && i < 50);
        chk("done", 1, done);
        cv <= 1'h0;
    endtask
    task automatic rd(input logic [7:0] idx, input logic [11:0] e);
        xfer(1'h0, idx, 32'h0);
        chk($sformatf("reg %h", idx), {20'h0, e}, rdata);
    endtask
    task automatic w;
        repeat (3) @(posedge clk);
    endtask
    // one sample pulse, then time for status and pin to settle
    task automatic smp(input int ch, input logic [11:0] c, input logic dac);
        @(posedge clk);
        if (dac) begin
            dmc[12*ch +: 12] <= c;
            dmv[ch] <= 1'h1;
        end else begin
            csc[12*ch +: 12] <= c;
            csv[ch] <= 1'h1;
        end
        @(posedge clk);
        csv <= 4'h0;
        dmv <= 4'h0;
        repeat (6) @(posedge clk);
    endtask
    task automatic summarize;
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // watchdog cuts a hang short
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        summarize();
    end
    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        chk("switch", 0, ds);
        rd(8'h11, 12'h001);
        rd(8'h1B, 12'h000);
        rd(8'h41, 12'hFFF);
        xfer(1'h0, 8'h05, 32'h0);
        chk("error", 1, err);
        $display("test reset done");
        xfer(1'h1, 8'h11, 32'h3);
        w();
        chk("switch", 1, ds);
        @(posedge clk) neg <= 1'h1;
        w();
        chk("switch", 0, ds);
        xfer(1'h1, 8'h11, 32'h3);
        w();
        chk("switch", 0, ds);
        xfer(1'h1, 8'h11, 32'h2);
        xfer(1'h1, 8'h11, 32'h2);
        w();
        chk("switch", 1, ds);
        @(posedge clk) neg <= 1'h0;
        pos <= 1'h1;
        w();
        chk("switch", 0, ds);
        @(posedge clk) pos <= 1'h0;
        xfer(1'h1, 8'h11, 32'h6);
        w();
        chk("switch", 1, ds);
        @(posedge clk) sleep <= 1'h1;
        w();
        chk("switch", 0, ds);
        @(posedge clk) sleep <= 1'h0;
        xfer(1'h1, 8'h11, 32'h2);
        xfer(1'h1, 8'h11, 32'h0);
        w();
        chk("switch", 0, ds);
        chk("pin", 1, oe);
        rd(8'h1E, 12'h030);
        rd(8'h1E, 12'h000);
        xfer(1'h1, 8'h1D, 32'h0);
        w();
        chk("clamp", 0, clamp);
        chk("pin", 0, oe);
        $display("test drain switch done");
        xfer(1'h1, 8'h1B, 32'h4);
        xfer(1'h1, 8'h41, 32'h100);
        xfer(1'h1, 8'h1D, 32'h11);
        xfer(1'h1, 8'h11, 32'h2);
        smp(0, 12'h800, 1'h0);
        chk("pin", 1, oe);
        chk("clamp", 1, clamp);
        chk("switch", 0, ds);
        rd(8'h29, 12'h800);
        rd(8'h1F, 12'h005);
        rd(8'h1E, 12'h001);
        rd(8'h1E, 12'h000);
        w();
        chk("clamp", 1, clamp);
        chk("switch", 0, ds);
        xfer(1'h1, 8'h1D, 32'h0);
        $display("test alarm done");
        fexp = 12'h800;
        for (int k = 1; k <= 5; k++) begin
            xfer(1'h1, 8'h10, k);
            smp(0, 12'h000, 1'h0);
            fexp = (k > 4) ? 12'h000 : fexp - (fexp >> k);
            rd(8'h29, fexp);
        end
        $display("test filter done");
        xfer(1'h1, 8'h10, 32'h0);
        xfer(1'h1, 8'h1C, 32'h1);
        smp(0, 12'h800, 1'h0);
        chk("pin", 0, oe);
        rd(8'h1E, 12'h001);
        xfer(1'h1, 8'h1B, 32'h5);
        w();
        chk("pin", 1, oe);
        xfer(1'h1, 8'h1C, 32'h0);
        smp(0, 12'h800, 1'h0);
        chk("pin", 0, oe);
        rd(8'h1E, 12'h001);
        $display("test mask and polarity done");
        xfer(1'h1, 8'h1B, 32'h6);
        smp(0, 12'h800, 1'h0);
        rd(8'h1E, 12'h001);
        rd(8'h1E, 12'h001);
        smp(0, 12'h000, 1'h0);
        rd(8'h1E, 12'h000);
        $display("test unlatched done");
        xfer(1'h1, 8'h1B, 32'h0);
        xfer(1'h1, 8'h10, 32'h8);
        w();
        chk("loop", 1, loop);
        xfer(1'h1, 8'h43, 32'h100);
        smp(1, 12'h800, 1'h1);
        smp(0, 12'h800, 1'h0);
        rd(8'h1E, 12'h002);
        $display("test closed loop done");
        summarize();
    end
endmodule
`default_nettype wire
